// File: verilog/smwd_pkg.sv
// Purpose: Shared constants and types for the shared memory window decoder.
// Assumes: Host addresses are 24 bits wide; the board's I/O port is byte wide.
// Notes: Switch inputs are 1 when the switch is closed (on).
package smwd_pkg;

    localparam int HOST_ADDR_W = 24;
    localparam int IO_ADDR_W = 10;
    localparam int REG_DATA_W = 8;
    localparam int OFFSET_W = 19;
    localparam int STAT_W = 2;
    localparam int IRQ_LINES = 8;

    // Window size codes, {hi, lo}; 1 means the pins 1-and-2 position.
    typedef enum logic [1:0]
    {
        SZ_64K = 2'h0,
        SZ_128K = 2'h1,
        SZ_256K = 2'h2,
        SZ_512K = 2'h3
    } smwd_size_e;

    // Register indices within the I/O port block.
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_MASK = 3'h2;
    localparam logic [2:0] REG_CONFIG = 3'h3;
    localparam logic [2:0] REG_BASE = 3'h4;

    // Field positions.
    localparam int CTRL_WIN_EN_BIT = 0;
    localparam int STAT_HIT_BIT = 0;
    localparam int STAT_CFG_ERR_BIT = 1;
    localparam int CFG_PORT_SEL_LSB = 0;
    localparam int CFG_SIZE_LSB = 3;
    localparam int CFG_PROG_64K_BIT = 5;
    localparam int CFG_FORCED_BIT = 6;

    // Reset values.
    localparam logic CTRL_RESET = 1'b0;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;
    localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;

    // I/O port block placement: base plus selector times the step.
    localparam logic [IO_ADDR_W-1:0] IO_PORT_BASE = 10'h100;
    localparam int IO_PORT_STEP_SHIFT = 6;
    localparam int IO_BLOCK_BITS = 3;

    // Base value whose upper nibble is this lies below the 1 MB boundary.
    localparam logic [3:0] BELOW_1MB_NIBBLE = 4'h0;

    typedef struct packed
    {
        logic valid;
        logic [HOST_ADDR_W-1:0] addr;
    } smwd_host_req_s;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [IO_ADDR_W-1:0] addr;
        logic [REG_DATA_W-1:0] wdata;
    } smwd_reg_req_s;

    typedef struct packed
    {
        logic win_en;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic [REG_DATA_W-1:0] rdata;
        logic claim;
        logic [OFFSET_W-1:0] offset;
        logic irq;
        logic [IRQ_LINES-1:0] irq_lines;
        logic prog_64k;
    } smwd_state_s;

endpackage

// File: verilog/smwd_win_match.sv
// Purpose: Compares the high host address bits against the window base.
// Assumes: Base and address carry host bits 23 to 16.
// Notes: Base bits inside the window size are ignored.
`timescale 1ns/1ns
module smwd_win_match
    import smwd_pkg::*;
(
    // Compare operands
    input wire logic [7:0] i_base,
    input wire logic [7:0] i_addr_hi,
    input wire smwd_pkg::smwd_size_e i_size,
    // Result
    output logic o_match
);
    logic [7:0] care;

    always_comb
    begin
        care = 8'hFF;
        case (i_size)
            SZ_64K:  care = 8'hFF;
            SZ_128K: care = 8'hFE;
            SZ_256K: care = 8'hFC;
            SZ_512K: care = 8'hF8;
            default: care = 8'hFF;
        endcase
        o_match = ((i_addr_hi ^ i_base) & care) == 8'h00;
    end
endmodule

// File: verilog/smwd_decoder.sv
// Purpose: Host-bus decode of a dual-ported memory window with an I/O port.
// Assumes: Switch and jumper inputs are static and synchronous to the clock.
// Notes: Claim, offset and read data appear one cycle after the request.
// What this block does
// - Open switch gives one, closed gives zero.
// - Switches one to eight drive bits 16-23.
// - Base low sixteen bits always zero.
// - Base reaches any 64K block below 16MB.
// - Port bit enables or disables the window.
// - Disabled window never answers; host enables one.
// - Window spans the jumper-selected size, or the fitted size if forced.
// - Two jumper inputs encode four window sizes.
// - 64K setting only on 128K boards.
// - Jumper selects 16K or 64K program memory.
// - All sizes placeable between 14 and 16MB.
// - Three switches set the I/O port address.
// - One closed switch picks the interrupt line.
// - All switches open drives no interrupt line.
`timescale 1ns/1ns
module smwd_decoder
    import smwd_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // Switches and jumpers, 1 = closed or pins 1-and-2
    input wire logic [10:0] i_base_and_port_switch_bank,
    input wire logic [IRQ_LINES-1:0] i_irq_select_switch_bank,
    input wire logic i_program_memory_size_jumper,
    input wire logic i_window_size_select_hi,
    input wire logic i_window_size_select_lo,
    input wire smwd_pkg::smwd_size_e i_fitted_mem_size,
    // Host memory cycle
    input wire smwd_pkg::smwd_host_req_s i_host_req,
    output logic o_mem_claim,
    output logic [OFFSET_W-1:0] o_mem_offset,
    // I/O port (register access)
    input wire smwd_pkg::smwd_reg_req_s i_reg_req,
    output logic [REG_DATA_W-1:0] o_rd_data,
    // Interrupts and configuration outputs
    output logic o_irq,
    output logic [IRQ_LINES-1:0] o_irq_lines,
    output logic o_prog_mem_64k
);
    import smwd_pkg::*;

    smwd_state_s st;
    smwd_state_s next_st;

    logic [7:0] base;
    logic [2:0] port_sel;
    logic [IO_ADDR_W-1:0] port_addr;
    logic port_hit;
    logic [2:0] reg_idx;
    smwd_size_e sel_size;
    smwd_size_e eff_size;
    logic size_forced;
    logic low_large;
    logic addr_match;
    logic hit_now;
    logic [OFFSET_W-1:0] off_mask;
    logic [IRQ_LINES-1:0] irq_closed;
    logic [IRQ_LINES-1:0] irq_pick;
    logic [STAT_W-1:0] stat_set;
    logic [STAT_W-1:0] stat_clr;

    // Closed switch reads as zero, so the value is the inverse.
    assign base = ~i_base_and_port_switch_bank[7:0];
    assign port_sel = ~i_base_and_port_switch_bank[10:8];
    assign port_addr = IO_PORT_BASE + {1'b0, port_sel, 6'h00};
    assign port_hit = (i_reg_req.addr[IO_ADDR_W-1:IO_BLOCK_BITS]
        == port_addr[IO_ADDR_W-1:IO_BLOCK_BITS]);
    assign reg_idx = i_reg_req.addr[IO_BLOCK_BITS-1:0];

    assign sel_size = smwd_size_e'({i_window_size_select_hi, i_window_size_select_lo});

    // A larger board jumpered for 64K keeps its full size and flags the fault.
    always_comb
    begin
        size_forced = (sel_size == SZ_64K) && (i_fitted_mem_size != SZ_128K);
        eff_size = size_forced ? i_fitted_mem_size : sel_size;
        low_large = (base[7:4] == BELOW_1MB_NIBBLE)
            && ((eff_size == SZ_256K) || (eff_size == SZ_512K));
    end

    smwd_win_match u_match
    (
        .i_base(base),
        .i_addr_hi(i_host_req.addr[23:16]),
        .i_size(eff_size),
        .o_match(addr_match)
    );

    // Offset keeps address bits 0-15 plus the size-dependent bits above.
    always_comb
    begin
        case (eff_size)
            SZ_64K:  off_mask = 19'h0FFFF;
            SZ_128K: off_mask = 19'h1FFFF;
            SZ_256K: off_mask = 19'h3FFFF;
            SZ_512K: off_mask = 19'h7FFFF;
            default: off_mask = 19'h0FFFF;
        endcase
    end

    assign hit_now = i_host_req.valid && st.win_en && addr_match;

    // Only the lowest closed switch drives, so one line at most.
    assign irq_closed = i_irq_select_switch_bank;
    assign irq_pick = irq_closed & (~irq_closed + 8'h01);

    always_comb
    begin
        stat_set = '0;
        stat_set[STAT_HIT_BIT] = hit_now;
        stat_set[STAT_CFG_ERR_BIT] = size_forced || low_large;
        stat_clr = '0;
        if (i_reg_req.rd && port_hit && (reg_idx == REG_STATUS))
        begin
            stat_clr = '1;
        end
    end

    always_comb
    begin
        next_st = st;
        next_st.claim = hit_now;
        next_st.offset = hit_now ? (i_host_req.addr[OFFSET_W-1:0] & off_mask) : '0;
        next_st.prog_64k = i_program_memory_size_jumper;
        // A new event in the clearing read's cycle survives the clear.
        next_st.status = (st.status & ~stat_clr) | stat_set;
        if (i_reg_req.wr && port_hit)
        begin
            case (reg_idx)
                REG_CTRL: next_st.win_en = i_reg_req.wdata[CTRL_WIN_EN_BIT];
                REG_MASK: next_st.mask = i_reg_req.wdata[STAT_W-1:0];
                default: next_st.mask = st.mask;
            endcase
        end
        next_st.rdata = '0;
        if (i_reg_req.rd && port_hit)
        begin
            case (reg_idx)
                REG_CTRL: next_st.rdata = {7'h00, st.win_en};
                REG_STATUS: next_st.rdata = {6'h00, st.status};
                REG_MASK: next_st.rdata = {6'h00, st.mask};
                REG_CONFIG: next_st.rdata = {1'b0, size_forced, st.prog_64k,
                    eff_size, port_sel};
                REG_BASE: next_st.rdata = base;
                default: next_st.rdata = '0;
            endcase
        end
        next_st.irq = |(next_st.status & next_st.mask);
        next_st.irq_lines = next_st.irq ? irq_pick : '0;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st <= '0;
            st.win_en <= CTRL_RESET;
            st.status <= STAT_RESET;
            st.mask <= MASK_RESET;
        end
        else if (i_clk_en)
        begin
            st <= next_st;
        end
    end

    assign o_mem_claim = st.claim;
    assign o_mem_offset = st.offset;
    assign o_rd_data = st.rdata;
    assign o_irq = st.irq;
    assign o_irq_lines = st.irq_lines;
    assign o_prog_mem_64k = st.prog_64k;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_req_taken;
        i_clk_en && i_host_req.valid;
    endsequence

    sequence s_claim_next;
        ##1 o_mem_claim;
    endsequence

    sequence s_read_of(logic [2:0] idx);
        i_clk_en && i_reg_req.rd && port_hit && (reg_idx == idx);
    endsequence

    sequence s_ctrl_write;
        i_clk_en && i_reg_req.wr && port_hit && (reg_idx == REG_CTRL);
    endsequence

    a_claim_needs_enable: assert property (o_mem_claim |-> st.win_en)
        else $error("Memory cycle claimed while window disabled.");

    a_claim_when_hit: assert property (
        (s_req_taken and (st.win_en && addr_match)) |-> s_claim_next)
        else $error("Matching enabled cycle was not claimed.");

    a_no_claim_miss: assert property (
        (i_clk_en && !addr_match) |=> !o_mem_claim)
        else $error("Cycle claimed outside the window.");

    a_disable_stops: assert property (
        (i_clk_en && i_reg_req.wr && port_hit && reg_idx == REG_CTRL
        && !i_reg_req.wdata[CTRL_WIN_EN_BIT]) |=> (i_clk_en [*2] |-> ##1 !o_mem_claim))
        else $error("Window still claimed after disable write.");

    a_offset_in_size: assert property (
        (i_clk_en && hit_now && eff_size == SZ_64K) |=> o_mem_offset[18:16] == 3'h0)
        else $error("Offset exceeds a 64K window.");

    a_base_switch_inv: assert property (
        (i_clk_en && i_reg_req.rd && port_hit && reg_idx == REG_BASE)
        |=> o_rd_data == ~$past(i_base_and_port_switch_bank[7:0]))
        else $error("Base readback not inverse of switches.");

    a_forced_no_64k: assert property (
        (i_fitted_mem_size != SZ_128K) |-> eff_size != SZ_64K)
        else $error("64K window on a board without 128K.");

    a_irq_one_line: assert property (
        $onehot0(o_irq_lines) && (o_irq_lines == '0 || o_irq))
        else $error("Interrupt lines not single or not backed by irq.");

    a_irq_all_open: assert property (
        (i_clk_en && i_irq_select_switch_bank == 8'h00) |=> o_irq_lines == 8'h00)
        else $error("Interrupt line driven with all switches open.");

    a_hit_sets_status: assert property (
        (i_clk_en && hit_now) |=> st.status[STAT_HIT_BIT])
        else $error("Window hit did not set its status bit.");

    a_prog_jumper: assert property (
        i_clk_en |=> o_prog_mem_64k == $past(i_program_memory_size_jumper))
        else $error("Program memory size output does not follow jumper.");

    a_offset_idle_zero: assert property (
        (i_clk_en && !hit_now) |=> o_mem_offset == '0)
        else $error("Offset not zero after an unclaimed cycle.");

    a_offset_low_bits: assert property (
        (i_clk_en && hit_now) |=> o_mem_offset[15:0] == $past(i_host_req.addr[15:0]))
        else $error("Offset low half differs from the host address.");

    a_offset_128k: assert property (
        (i_clk_en && hit_now && eff_size == SZ_128K) |=> o_mem_offset[18:17] == 2'h0)
        else $error("Offset exceeds a 128K window.");

    a_offset_256k: assert property (
        (i_clk_en && hit_now && eff_size == SZ_256K) |=> o_mem_offset[18] == 1'b0)
        else $error("Offset exceeds a 256K window.");

    a_offset_512k: assert property (
        (i_clk_en && hit_now && eff_size == SZ_512K)
        |=> o_mem_offset == $past(i_host_req.addr[18:0]))
        else $error("Offset does not span the whole 512K window.");

    a_port_miss_quiet: assert property (
        (i_clk_en && i_reg_req.rd && !port_hit) |=> o_rd_data == 8'h00)
        else $error("Read outside the port block returned data.");

    a_rdata_idle_zero: assert property (
        (i_clk_en && !i_reg_req.rd) |=> o_rd_data == 8'h00)
        else $error("Read data not zero without a read.");

    a_ctrl_readback: assert property (
        s_read_of(REG_CTRL) |=> o_rd_data == {7'h00, $past(st.win_en)})
        else $error("Control readback differs from the window enable.");

    a_ctrl_write_lands: assert property (
        s_ctrl_write |=> st.win_en == $past(i_reg_req.wdata[CTRL_WIN_EN_BIT]))
        else $error("Control write did not set the window enable.");

    a_enable_holds: assert property (
        (i_clk_en && !(i_reg_req.wr && port_hit && reg_idx == REG_CTRL)) |=> $stable(st.win_en))
        else $error("Window enable changed without a control write.");

    a_state_frozen: assert property (
        !i_clk_en |=> $stable(st))
        else $error("State changed while the clock enable was low.");

    a_status_clears: assert property (
        (i_clk_en && i_reg_req.rd && port_hit && reg_idx == REG_STATUS && stat_set == '0)
        |=> st.status == '0)
        else $error("Status read did not clear the status bits.");

    a_status_readback: assert property (
        s_read_of(REG_STATUS) |=> o_rd_data == {6'h00, $past(st.status)})
        else $error("Status readback differs from the status bits.");

    a_irq_level: assert property (
        o_irq == |(st.status & st.mask))
        else $error("Interrupt level differs from masked status.");

    a_lines_need_switch: assert property (
        i_clk_en |=> (o_irq_lines & ~$past(i_irq_select_switch_bank)) == 8'h00)
        else $error("Interrupt line driven without its closed switch.");

    a_config_size: assert property (
        (s_read_of(REG_CONFIG) and !size_forced) |=> o_rd_data[CFG_SIZE_LSB + 1]
        == $past(i_window_size_select_hi) && o_rd_data[CFG_SIZE_LSB] == $past(i_window_size_select_lo))
        else $error("Config size field differs from the size inputs.");

    a_forced_flags: assert property (
        (i_clk_en && size_forced) |=> st.status[STAT_CFG_ERR_BIT])
        else $error("Refused 64K setting did not flag a config error.");

    a_low_large_flags: assert property (
        (i_clk_en && low_large) |=> st.status[STAT_CFG_ERR_BIT])
        else $error("Large window below 1MB did not flag a config error.");

    a_config_prog: assert property (
        s_read_of(REG_CONFIG) |=> o_rd_data[CFG_PROG_64K_BIT] == $past(st.prog_64k))
        else $error("Config program size bit differs from the jumper copy.");

    a_config_port: assert property (
        s_read_of(REG_CONFIG) |=> o_rd_data[2:0] == ~$past(i_base_and_port_switch_bank[10:8]))
        else $error("Config port field differs from the port switches.");
endmodule

// File: verif/smwd_host_model.sv
// Purpose: Host processor model issuing memory cycles and I/O port accesses.
// Assumes: Requests change by non-blocking assignment right after a rising edge.
// Notes: Released address and data lines carry the inverse of the last value, never a stale copy; strobes drop to zero.
`timescale 1ns/1ns
module smwd_host_model
    import smwd_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Host bus
    output smwd_pkg::smwd_host_req_s o_host_req,
    output smwd_pkg::smwd_reg_req_s o_reg_req
);
    initial
    begin
        o_host_req = '0;
        o_reg_req = '0;
    end

    task automatic mem(input logic [23:0] a);
        @(posedge i_ref_clk);
        o_host_req <= '{1'b1, a};
        @(posedge i_ref_clk);
        o_host_req <= '{1'b0, ~a};
    endtask

    task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_req <= '{w, ~w, a, d};
        @(posedge i_ref_clk);
        o_reg_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// File: verif/test_smwd_decoder.sv
// Purpose: Self-checking bench for the shared memory window decoder.
// Assumes: Switch inputs are 1 when closed; outputs land one cycle after a request.
// Notes: Only one board is modelled, so the host never enables two windows.
`timescale 1ns/1ns
module test_smwd_decoder;
    import smwd_pkg::*;
    logic ref_clk, rst = 1, clk_en = 1, prog_j = 0, sz_hi = 0, sz_lo = 0;
    logic [10:0] sw = 11'h7FF;
    logic [7:0] irq_sw = 8'h00;
    smwd_size_e fitted = SZ_128K;
    smwd_host_req_s host_req;
    smwd_reg_req_s reg_req;
    logic claim, irq, prog64;
    logic [OFFSET_W-1:0] offs;
    logic [7:0] rdata, lines;
    logic [9:0] io_base = 10'h100;
    int err_total = 0, num_checks = 0;

    smwd_decoder u_smwd_decoder (.i_ref_clk(ref_clk), .i_sys_rst(rst), .i_clk_en(clk_en),
        .i_base_and_port_switch_bank(sw), .i_irq_select_switch_bank(irq_sw),
        .i_program_memory_size_jumper(prog_j), .i_window_size_select_hi(sz_hi),
        .i_window_size_select_lo(sz_lo), .i_fitted_mem_size(fitted), .i_host_req(host_req),
        .o_mem_claim(claim), .o_mem_offset(offs), .i_reg_req(reg_req), .o_rd_data(rdata),
        .o_irq(irq), .o_irq_lines(lines), .o_prog_mem_64k(prog64));
    smwd_host_model u_smwd_host_model (.i_ref_clk(ref_clk), .o_host_req(host_req),
        .o_reg_req(reg_req));

    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        u_smwd_host_model.io(1'b1, a, d);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        u_smwd_host_model.io(1'b0, a, 8'h00);
        #1 chk("rd_data", exp, rdata);
    endtask

    task automatic mchk(input logic [23:0] a, input logic c, input logic [23:0] o);
        u_smwd_host_model.mem(a);
        #1 chk("claim", c, claim);
        chk("offset", o, offs);
    endtask

    task automatic t_base();
        logic [7:0] b;
        for (int i = 0; i < 3; i++)
        begin
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'h5A;
            @(posedge ref_clk);
            sw <= {3'h7, ~b};
            rd(io_base + REG_BASE, b);
            mchk({b, 16'h0000}, 1'b1, 24'h0);
            mchk({b, 16'hFFFF}, 1'b1, 24'hFFFF);
            mchk({b ^ 8'h01, 16'h0000}, 1'b0, 24'h0);
        end
    endtask

    task automatic t_size();
        logic [23:0] span;
        for (int s = 0; s < 4; s++)
        begin
            span = 24'h10000 << s;
            @(posedge ref_clk);
            sw <= {3'h7, ~8'hE0};
            {sz_hi, sz_lo} <= 2'(s);
            fitted <= (s == 0) ? SZ_128K : smwd_size_e'(s[1:0]);
            rd(io_base + REG_CONFIG, 8'(s) << 3);
            mchk(24'hE00000 + span - 1, 1'b1, span - 1);
            mchk(24'hE00000 + span, 1'b0, 24'h0);
        end
    endtask

    // A 64K setting on a 256K board falls back to the fitted size and flags it.
    task automatic t_forced();
        @(posedge ref_clk);
        sw <= {3'h7, ~8'hE5};
        {sz_hi, sz_lo} <= 2'h0;
        fitted <= SZ_256K;
        rd(io_base + REG_CONFIG, 8'h50);
        mchk(24'hE40000, 1'b1, 24'h0);
        rd(io_base + REG_STATUS, 8'h03);
        rd(io_base + REG_STATUS, 8'h02);
    endtask

    task automatic t_en();
        @(posedge ref_clk);
        sw <= {3'h7, ~8'hE0};
        fitted <= SZ_128K;
        wr(io_base + REG_CTRL, 8'h00);
        mchk(24'hE00100, 1'b0, 24'h0);
        wr(io_base + REG_CTRL, 8'h01);
        rd(io_base + REG_CTRL, 8'h01);
        mchk(24'hE00100, 1'b1, 24'h100);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        mchk(24'hE00100, 1'b0, 24'h0);
        @(posedge ref_clk);
        clk_en <= 1'b1;
    endtask

    task automatic t_prog();
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge ref_clk);
            prog_j <= v[0];
            @(posedge ref_clk);
            #1 chk("prog_64k", v[0], prog64);
        end
    endtask

    task automatic t_port();
        for (int p = 0; p < 8; p++)
        begin
            @(posedge ref_clk);
            sw[10:8] <= ~p[2:0];
            io_base = 10'h100 + {p[2:0], 6'h00};
            wr(io_base + REG_CTRL, 8'h01);
            rd(io_base + REG_CTRL, 8'h01);
            rd(io_base ^ 10'h040, 8'h00);
            rd(io_base + 10'h005, 8'h00);
        end
        @(posedge ref_clk);
        sw[10:8] <= 3'h7;
        io_base = 10'h100;
    endtask

    task automatic t_irq();
        @(posedge ref_clk);
        irq_sw <= 8'h08;
        rd(io_base + REG_STATUS, 8'h03);
        wr(io_base + REG_MASK, 8'h01);
        #1 chk("irq", 1'b0, irq);
        mchk(24'hE00010, 1'b1, 24'h10);
        chk("irq", 1'b1, irq);
        chk("irq_lines", 8'h08, lines);
        @(posedge ref_clk);
        irq_sw <= 8'h00;
        @(posedge ref_clk);
        #1 chk("irq_lines", 8'h00, lines);
        rd(io_base + REG_STATUS, 8'h01);
        chk("irq", 1'b0, irq);
        wr(io_base + REG_MASK, 8'h00);
        mchk(24'hE00010, 1'b1, 24'h10);
        chk("irq", 1'b0, irq);
    endtask

    // A mid-run reset must close the window and empty the status register.
    task automatic t_rst();
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        rd(io_base + REG_CTRL, 8'h00);
        rd(io_base + REG_STATUS, 8'h00);
        mchk(24'hE00010, 1'b0, 24'h0);
    endtask

    initial
    begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Watchdog sized far above the few hundred cycles the scenarios need.
    initial
    begin
        #80000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 0;
        wr(io_base + REG_CTRL, 8'h01);
        t_prog();
        t_base();
        t_size();
        t_forced();
        t_en();
        t_port();
        t_irq();
        t_rst();
        report_and_stop();
    end
endmodule
